// File: msol_host_model.sv
// host controller model that starts motion only after ready
`timescale 1ns/1ps
`default_nettype none
module msol_host_model
    import msol_pkg::*;
(
    // clock and request from the bench, ready flag from the block
    input wire logic mclk,
    input wire logic startReq,
    input wire logic readyFlag,
    // commands toward the block
    output var logic startCmd,
    output var logic [STEPS_W-1:0] stepsPerRev
);
    // resolution kept a whole multiple of fifty
    assign stepsPerRev = 16'h0064;
    // one start pulse, only once ready is seen
    initial startCmd = 1'b0;
    always @(posedge mclk)
    begin
        startCmd <= startReq && readyFlag && !startCmd;
    end
endmodule // msol_host_model
`default_nettype wire

// File: msol_move_stretch.sv
// moving flag with a programmable minimum on time
`timescale 1ns/1ps
`default_nettype none
module msol_move_stretch
    import msol_pkg::*;
#(
    parameter int unsigned MS_CYC = MS_CYCLES // cycles per millisecond
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // motion and configuration
    input wire logic motorOperating,
    input wire logic [MIN_ON_W-1:0] minOnMs,
    // registered moving flag
    output var logic moveFlag
);
    // all state of this module
    typedef struct packed
    {
        logic flag; // moving flag
        logic [MIN_ON_W-1:0] remain; // milliseconds still to hold
        logic [PRESCALE_W-1:0] prescale; // millisecond divider
    } msol_move_s;

    msol_move_s st_q; // registered state
    msol_move_s st_d; // next state
    logic msTick; // one-cycle enable each millisecond while the hold time counts down

    // hold timer starts at the rising edge of the flag
    always_comb
    begin
        msTick = st_q.prescale == PRESCALE_W'(MS_CYC - 1);
        st_d = st_q;
        if (motorOperating && !st_q.flag)
        begin
            // fresh start: load the hold time, align the divider
            st_d.remain = minOnMs; // [R9]
            st_d.prescale = '0;
        end
        else if (st_q.remain != '0)
        begin
            // count the hold time down in milliseconds
            st_d.prescale = msTick ? '0 : PRESCALE_W'(st_q.prescale + 1'b1);
            st_d.remain = msTick ? MIN_ON_W'(st_q.remain - 1'b1) : st_q.remain; // [R9]
        end
        else
        begin
            st_d.prescale = '0; // idle divider
        end
        st_d.flag = motorOperating || (st_d.remain != '0); // [R8] [R9]
        if (!resetn)
        begin
            st_d = '0; // [R22]
        end
    end

    // state register
    always_ff @(posedge mclk)
    begin
        st_q <= st_d;
    end

    assign moveFlag = st_q.flag;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_move_follows: assert property (motorOperating |=> moveFlag) // [R8]
        else $error("moving flag low while motor operates");
    a_move_min_hold: assert property ($rose(moveFlag) && minOnMs != '0 |-> moveFlag[*8]) // [R9]
        else $error("moving flag dropped inside minimum time");
endmodule : msol_move_stretch
`default_nettype wire

// File: msol_pkg.sv
// shared constants and types for the motion status output logic
package msol_pkg;
    // clock rate and millisecond time base
    localparam int unsigned CLK_HZ = 100_000_000; // mclk frequency in hertz
    localparam int unsigned MS_TIME_US = 1000; // one millisecond expressed in microseconds
    localparam int unsigned MS_CYCLES = CLK_HZ / 1_000_000 * MS_TIME_US; // mclk cycles per millisecond
    localparam int unsigned PRESCALE_W = 20; // width of the millisecond prescaler
    // field widths
    localparam int unsigned POS_W = 24; // signed step position width
    localparam int unsigned MIN_ON_W = 8; // minimum moving time, 0 to 255 ms
    localparam int unsigned STEPS_W = 16; // step resolution width
    localparam int unsigned GEN_N = 16; // number of general pass-through signals
    localparam int unsigned IDX_W = 4; // width of a bit selector
    localparam int unsigned START_N = 13; // motion start inputs echoed
    localparam int unsigned SELECT_N = 6; // data select inputs echoed
    localparam int unsigned WIN_N = 3; // number of position windows
    // timing output: 7.2 degrees is one fiftieth of a turn
    localparam logic [STEPS_W-1:0] TIM_DIVISOR = 16'h0032; // timing pulses per revolution
    // home flag function selection codes
    localparam logic HOME_SEL_AT_HOME = 1'h0; // flag at home position while stopped
    localparam logic HOME_SEL_ORIGIN_DONE = 1'h1; // flag after origin established
    // values after reset
    localparam logic [POS_W-1:0] BOUND_RESET = 24'h000000; // window bounds after reset
    localparam logic [STEPS_W-1:0] PHASE_RESET = 16'h0000; // timing phase after reset
    localparam logic [POS_W-1:0] HOME_POSITION = 24'h000000; // command position of home
endpackage : msol_pkg

// File: msol_status_out.sv
// status outputs of the stepping motor driver toward the host controller
//
// How it works
// R1: ready only when idle, enabled, alarm free
// R2: ready low during tool or serial commands
// R3: host commands only after ready seen
// R4: setting 0: home at position zero, stopped
// R5: setting 0: no origin keeps home low
// R6: setting 1: home once origin is established
// R7: setting 1: home holds until motor leaves
// R8: moving flag high while motor operates
// R9: moving flag held a minimum 0-255 ms
// R10: wrapped window flags outside the band
// R11: normal window flags inside the band
// R12: windows use command position, also stopped
// R13: six signed 24-bit bounds, reset zero
// R14: timing pulse every 7.2 degrees rotation
// R15: resolution should be multiple of fifty
// R16: busy while maintenance command processes
// R17: echo outputs mirror listed inputs
// R18: start echoes show inputs, not motion
// R19: network bit drives assigned direct output
// R20: direct input drives assigned network bit
// R21: direct input level setting applied first
// R22: clocked outputs; status cleared on reset
`timescale 1ns/1ps
`default_nettype none
module msol_status_out
    import msol_pkg::*;
#(
    parameter int unsigned DIRECT_IN_N = 8, // direct inputs available
    parameter int unsigned DIRECT_OUT_N = 6, // direct outputs available
    parameter int unsigned MS_CYC = MS_CYCLES // cycles per millisecond
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // motion and alarm state
    input wire logic motorOperating,
    input wire logic alarmPresent,
    // inputs that are echoed
    input wire logic [START_N-1:0] startInputs,
    input wire logic freeInput,
    input wire logic currentOffInput,
    input wire logic stopInput,
    input wire logic [SELECT_N-1:0] dataSelectInputs,
    input wire logic positiveLimitInput,
    input wire logic negativeLimitInput,
    input wire logic homeSensorInput,
    input wire logic slitInput,
    // functions that block readiness or report busy
    input wire logic panelFunctionActive,
    input wire logic serialConfigActive,
    input wire logic maintenanceActive,
    // position and origin
    input wire logic [POS_W-1:0] commandPosition,
    input wire logic originSet,
    input wire logic originEvent,
    input wire logic homeFunctionSel,
    // configuration
    input wire logic [MIN_ON_W-1:0] moveMinOnMs,
    input wire logic boundWrite,
    input wire logic [1:0] boundIndex,
    input wire logic boundIsNegative,
    input wire logic [POS_W-1:0] boundValue,
    // step stream for the timing output
    input wire logic stepPulse,
    input wire logic stepForward,
    input wire logic [STEPS_W-1:0] stepsPerRev,
    // general pass-through configuration and data
    input wire logic [GEN_N-1:0] networkInBits,
    input wire logic [DIRECT_IN_N-1:0] directInputs,
    input wire logic [DIRECT_IN_N-1:0] directInLevel,
    input wire logic [GEN_N-1:0] genFromDirect,
    input wire logic [GEN_N*IDX_W-1:0] genSrcIndex,
    input wire logic [DIRECT_OUT_N-1:0] directOutEnable,
    input wire logic [DIRECT_OUT_N*IDX_W-1:0] directOutSel,
    input wire logic [GEN_N-1:0] networkOutEnable,
    input wire logic [GEN_N*IDX_W-1:0] networkOutSel,
    // status flags
    output var logic readyFlag,
    output var logic homeFlag,
    output var logic moveFlag,
    output var logic window1Flag,
    output var logic window2Flag,
    output var logic window3Flag,
    output var logic stepCyclePulse,
    output var logic internalBusyFlag,
    // echo outputs
    output var logic [START_N-1:0] startEcho,
    output var logic freeEcho,
    output var logic currentOffEcho,
    output var logic stopEcho,
    output var logic [SELECT_N-1:0] dataSelectEcho,
    output var logic positiveLimitEcho,
    output var logic negativeLimitEcho,
    output var logic homeSensorEcho,
    output var logic slitEcho,
    // pass-through outputs
    output var logic [DIRECT_OUT_N-1:0] directOutputs,
    output var logic [GEN_N-1:0] networkOutBits
);
    // all state of the top module
    typedef struct packed
    {
        logic ready; // ready flag
        logic home; // home flag
        logic busy; // internal busy flag
        logic homeHold; // origin-done latch
        logic [POS_W-1:0] originPos; // position at the origin event
        logic [WIN_N-1:0][POS_W-1:0] posBound; // window positive bounds
        logic [WIN_N-1:0][POS_W-1:0] negBound; // window negative bounds
        logic timPulse; // timing output
        logic [STEPS_W-1:0] timPhase; // steps into current timing cycle
        logic [START_N-1:0] startEcho; // start input echoes
        logic freeEcho; // free input echo
        logic offEcho; // current-off echo
        logic stopEcho; // stop echo
        logic [SELECT_N-1:0] selEcho; // data select echoes
        logic posLimEcho; // positive limit echo
        logic negLimEcho; // negative limit echo
        logic homeSenEcho; // home sensor echo
        logic slitEcho; // slit echo
        logic [DIRECT_OUT_N-1:0] dirOut; // direct outputs
        logic [GEN_N-1:0] netOut; // network output bits
    } msol_top_s;

    msol_top_s st_q; // registered state
    msol_top_s st_d; // next state
    logic [GEN_N-1:0] genValue; // general signal values
    logic [GEN_N-1:0] dirLevelled; // direct inputs after level setting
    logic [STEPS_W-1:0] timPeriod; // steps per timing pulse
    logic [STEPS_W-1:0] timNext; // timing phase after a step
    logic [WIN_N-1:0] winFlags; // registered window flags

    // picks one 4-bit selector out of a packed list
    function automatic logic [IDX_W-1:0] selIdx(input logic [63:0] list, input int unsigned k);
        selIdx = list[k*IDX_W +: IDX_W];
    endfunction

    // picks one bit of a 16-bit vector
    function automatic logic pickBit(input logic [GEN_N-1:0] vec, input logic [IDX_W-1:0] idx);
        pickBit = vec[idx];
    endfunction

    // moving flag with minimum on time
    msol_move_stretch #(
        .MS_CYC(MS_CYC)
    ) u_move (
        .mclk(mclk),
        .resetn(resetn),
        .motorOperating(motorOperating),
        .minOnMs(moveMinOnMs),
        .moveFlag(moveFlag)
    );

    // three window comparators on the command position
    msol_win_if winBus[WIN_N] ();
    generate
        for (genvar w = 0; w < WIN_N; w++)
        begin : g_win
            assign winBus[w].posBound = st_q.posBound[w];
            assign winBus[w].negBound = st_q.negBound[w];
            assign winBus[w].position = commandPosition; // [R12]
            msol_window_cmp u_cmp (
                .mclk(mclk),
                .resetn(resetn),
                .win(winBus[w].cmp),
                .windowFlag(winFlags[w])
            );
        end
    endgenerate

    // next state of ready, home, busy and timing flags, echoes and pass-through
    always_comb
    begin
        st_d = st_q;
        // readiness: every blocking condition keeps it low
        st_d.ready = ~|startInputs && !freeInput && !currentOffInput && !stopInput
            && !alarmPresent && !motorOperating; // [R1]
        if (panelFunctionActive || serialConfigActive)
        begin
            st_d.ready = 1'h0; // [R2]
        end
        // origin-done latch: a new origin wins over leaving it
        if (originEvent)
        begin
            st_d.homeHold = 1'h1; // [R6]
            st_d.originPos = commandPosition;
        end
        else if (moveFlag && commandPosition != st_q.originPos)
        begin
            st_d.homeHold = 1'h0; // [R7]
        end
        // home flag by function selection
        if (homeFunctionSel == HOME_SEL_ORIGIN_DONE)
        begin
            st_d.home = originSet && st_d.homeHold; // [R6] [R7]
        end
        else
        begin
            st_d.home = originSet && commandPosition == HOME_POSITION && !moveFlag; // [R4] [R5]
        end
        // window bound storage
        if (boundWrite && boundIndex != 2'h3)
        begin
            if (boundIsNegative)
            begin
                st_d.negBound[boundIndex] = boundValue; // [R13]
            end
            else
            begin
                st_d.posBound[boundIndex] = boundValue; // [R13]
            end
        end
        // timing output: one pulse per fiftieth of a turn
        timPeriod = stepsPerRev / TIM_DIVISOR;
        timNext = st_q.timPhase;
        if (stepForward)
        begin
            timNext = (st_q.timPhase >= STEPS_W'(timPeriod - 1'b1)) ? PHASE_RESET
                : STEPS_W'(st_q.timPhase + 1'b1);
        end
        else
        begin
            timNext = (st_q.timPhase == PHASE_RESET || st_q.timPhase >= timPeriod)
                ? STEPS_W'(timPeriod - 1'b1) : STEPS_W'(st_q.timPhase - 1'b1);
        end
        st_d.timPulse = 1'h0;
        if (stepPulse && timPeriod != PHASE_RESET)
        begin
            st_d.timPhase = timNext;
            st_d.timPulse = timNext == PHASE_RESET; // [R14]
        end
        // maintenance busy
        st_d.busy = maintenanceActive; // [R16]
        // echoes copy input state only
        st_d.startEcho = startInputs; // [R17] [R18]
        st_d.freeEcho = freeInput; // [R17]
        st_d.offEcho = currentOffInput; // [R17]
        st_d.stopEcho = stopInput; // [R17]
        st_d.selEcho = dataSelectInputs; // [R17]
        st_d.posLimEcho = positiveLimitInput; // [R17]
        st_d.negLimEcho = negativeLimitInput; // [R17]
        st_d.homeSenEcho = homeSensorInput; // [R17]
        st_d.slitEcho = slitInput; // [R17]
        // general signals from a network bit or a levelled direct input
        dirLevelled = GEN_N'(directInputs ^ directInLevel); // [R21]
        for (int unsigned g = 0; g < GEN_N; g++)
        begin
            genValue[g] = genFromDirect[g] ? pickBit(dirLevelled, selIdx(64'(genSrcIndex), g)) // [R20]
                : pickBit(networkInBits, selIdx(64'(genSrcIndex), g)); // [R19]
        end
        // route general signals to direct outputs and network bits
        for (int unsigned k = 0; k < DIRECT_OUT_N; k++)
        begin
            st_d.dirOut[k] = directOutEnable[k] && pickBit(genValue, selIdx(64'(directOutSel), k)); // [R19]
        end
        for (int unsigned b = 0; b < GEN_N; b++)
        begin
            st_d.netOut[b] = networkOutEnable[b] && pickBit(genValue, selIdx(64'(networkOutSel), b)); // [R20]
        end
        // reset clears status and bounds; echoes keep following
        if (!resetn)
        begin
            st_d.ready = 1'h0; // [R22]
            st_d.home = 1'h0;
            st_d.busy = 1'h0;
            st_d.homeHold = 1'h0;
            st_d.originPos = HOME_POSITION;
            st_d.posBound = {WIN_N{BOUND_RESET}}; // [R13]
            st_d.negBound = {WIN_N{BOUND_RESET}};
            st_d.timPulse = 1'h0;
            st_d.timPhase = PHASE_RESET;
        end
    end

    // single state register
    always_ff @(posedge mclk)
    begin
        st_q <= st_d;
    end

    // outputs straight from the state register; window flags from the comparator registers
    assign readyFlag = st_q.ready;
    assign homeFlag = st_q.home;
    assign window1Flag = winFlags[0];
    assign window2Flag = winFlags[1];
    assign window3Flag = winFlags[2];
    assign stepCyclePulse = st_q.timPulse;
    assign internalBusyFlag = st_q.busy;
    assign startEcho = st_q.startEcho;
    assign freeEcho = st_q.freeEcho;
    assign currentOffEcho = st_q.offEcho;
    assign stopEcho = st_q.stopEcho;
    assign dataSelectEcho = st_q.selEcho;
    assign positiveLimitEcho = st_q.posLimEcho;
    assign negativeLimitEcho = st_q.negLimEcho;
    assign homeSensorEcho = st_q.homeSenEcho;
    assign slitEcho = st_q.slitEcho;
    assign directOutputs = st_q.dirOut;
    assign networkOutBits = st_q.netOut;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_ready_blocked: assert property (alarmPresent || stopInput || currentOffInput // [R1]
        || motorOperating || |startInputs |=> !readyFlag)
        else $error("ready while a blocking condition holds");
    a_ready_tools: assert property (panelFunctionActive || serialConfigActive |=> !readyFlag) // [R2]
        else $error("ready during tool or serial command");
    a_home_at_zero: assert property (homeFunctionSel == HOME_SEL_AT_HOME && originSet // [R4]
        && commandPosition == HOME_POSITION && !moveFlag |=> homeFlag)
        else $error("home flag missing at home position");
    a_home_no_origin: assert property (!originSet |=> !homeFlag) // [R5]
        else $error("home flag without origin");
    a_home_origin_done: assert property (originEvent ##1 (originSet && !moveFlag // [R6] [R7]
        && homeFunctionSel == HOME_SEL_ORIGIN_DONE) |=> homeFlag)
        else $error("home flag missing after origin set");
    a_tim_wrap: assert property (stepPulse && stepForward && timPeriod != PHASE_RESET // [R14]
        && st_q.timPhase == STEPS_W'(timPeriod - 1'b1)
        |=> stepCyclePulse ##1 (!stepCyclePulse || timPeriod == 16'h0001))
        else $error("timing pulse wrong at cycle boundary");
    a_busy_follow: assert property (maintenanceActive |=> internalBusyFlag) // [R16]
        else $error("busy flag missing during maintenance");
    a_echo_stop: assert property (##1 stopEcho == $past(stopInput) && slitEcho == $past(slitInput)) // [R17]
        else $error("echo does not mirror its input");
    a_echo_start: assert property (##1 startEcho == $past(startInputs)) // [R18]
        else $error("start echo differs from start inputs");
    a_pass_net: assert property (directOutEnable[0] && !genFromDirect[selIdx(64'(directOutSel), 0)] // [R19]
        |=> directOutputs[0] == $past(networkInBits[selIdx(64'(genSrcIndex), selIdx(64'(directOutSel), 0))]))
        else $error("direct output does not follow network bit");
endmodule : msol_status_out
`default_nettype wire

// File: msol_win_if.sv
// bundle carrying one position window and the position it is compared with
`timescale 1ns/1ps
`default_nettype none
interface msol_win_if
    import msol_pkg::*;
();
    logic [POS_W-1:0] posBound; // positive direction bound, signed
    logic [POS_W-1:0] negBound; // negative direction bound, signed
    logic [POS_W-1:0] position; // command position, signed
    // comparator side reads everything
    modport cmp (input posBound, input negBound, input position);
    // owner side drives everything
    modport owner (output posBound, output negBound, output position);
endinterface : msol_win_if
`default_nettype wire

// File: msol_window_cmp.sv
// one position window comparator with registered flag
`timescale 1ns/1ps
`default_nettype none
module msol_window_cmp
    import msol_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // window and position
    msol_win_if.cmp win,
    // registered window flag
    output var logic windowFlag
);
    // all state of this module
    typedef struct packed
    {
        logic flag; // window flag
    } msol_win_s;

    msol_win_s st_q; // registered state
    msol_win_s st_d; // next state
    logic wrapped; // positive bound below negative bound

    // compare against command position, also while stopped
    always_comb
    begin
        wrapped = $signed(win.posBound) < $signed(win.negBound);
        st_d = st_q;
        if (wrapped)
        begin
            // outside band between the bounds
            st_d.flag = ($signed(win.position) <= $signed(win.posBound))
                || ($signed(win.position) >= $signed(win.negBound)); // [R10] [R12]
        end
        else
        begin
            // inside band, includes equal bounds
            st_d.flag = ($signed(win.negBound) <= $signed(win.position))
                && ($signed(win.position) <= $signed(win.posBound)); // [R11] [R12]
        end
        if (!resetn)
        begin
            st_d.flag = 1'h0; // [R22]
        end
    end

    // state register
    always_ff @(posedge mclk)
    begin
        st_q <= st_d;
    end

    assign windowFlag = st_q.flag;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_window_wrap: assert property (wrapped && $signed(win.position) > $signed(win.posBound) // [R10]
        && $signed(win.position) < $signed(win.negBound) |=> !windowFlag)
        else $error("window flag set between wrapped bounds");
    a_window_span: assert property (!wrapped && $signed(win.position) == $signed(win.negBound) // [R11]
        ##1 $stable(win.position) && $stable(win.negBound) && $stable(win.posBound) |=> windowFlag)
        else $error("window flag missing at negative bound");
endmodule : msol_window_cmp
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the motion status output logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // stimulus state, all valued at time zero
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] blk = 8'h00;
    logic [12:0] stIn = 13'h0000;
    logic [9:0] eIn = 10'h000;
    logic [31:0] rnd = 32'h24B745F2;
    logic maint = 1'b0, startReq = 1'b0, startCmd, oSet = 1'b0, oEvt = 1'b0, hSel = 1'b0;
    logic bWr = 1'b0, bNeg = 1'b0, stp = 1'b0, fwd = 1'b1;
    logic [1:0] bIdx = 2'h0;
    logic [23:0] cmdPos = 24'h000000, bVal = 24'h000000;
    logic [15:0] spr, netIn = 16'h0000, netOut, gFd = 16'h0002, nEn = 16'h8000;
    logic [63:0] gIdx = 64'h0000000000000030, nSel = 64'h1000000000000000;
    logic [7:0] dIn = 8'h00, dLvl = 8'h00, minMs = 8'h02;
    logic [5:0] dOut, dsE, oEn = 6'h01;
    logic [23:0] oSel = 24'h000000;
    logic rdy, home, mov, w1, w2, w3, tim, busy, fr, co, so, pl, nl, hs, sl;
    logic [12:0] stE;
    // window positions and expected flags {w3,w2,w1}
    logic [23:0] posT [5] = '{24'hFFFFFA, 24'hFFFFFB, 24'h000000, 24'h00000A, 24'h00000B};
    logic [15:0] winT [5] = '{16'h0002, 16'h0003, 16'h0005, 16'h0003, 16'h0002};
    int fail_count = 0, cmp_count = 0, pulses = 0;
    int selQ[$];
    logic [15:0] expQ[$];
    event chk;
    msol_host_model u_host (.mclk(mclk), .startReq(startReq), .readyFlag(rdy), .startCmd(startCmd),
        .stepsPerRev(spr));
    msol_status_out #(.MS_CYC(10)) u_dut (.mclk(mclk), .resetn(resetn), .motorOperating(blk[0]),
        .alarmPresent(blk[1]), .startInputs(stIn | {8'h00, startCmd, 3'h0, blk[7]}), .freeInput(blk[2]),
        .currentOffInput(blk[3]), .stopInput(blk[4]), .dataSelectInputs(eIn[9:4]), .positiveLimitInput(eIn[3]),
        .negativeLimitInput(eIn[2]), .homeSensorInput(eIn[1]), .slitInput(eIn[0]), .panelFunctionActive(blk[5]),
        .serialConfigActive(blk[6]), .maintenanceActive(maint), .commandPosition(cmdPos), .originSet(oSet),
        .originEvent(oEvt), .homeFunctionSel(hSel), .moveMinOnMs(minMs), .boundWrite(bWr), .boundIndex(bIdx),
        .boundIsNegative(bNeg), .boundValue(bVal), .stepPulse(stp), .stepForward(fwd), .stepsPerRev(spr),
        .networkInBits(netIn), .directInputs(dIn), .directInLevel(dLvl), .genFromDirect(gFd), .genSrcIndex(gIdx),
        .directOutEnable(oEn), .directOutSel(oSel), .networkOutEnable(nEn), .networkOutSel(nSel),
        .readyFlag(rdy), .homeFlag(home), .moveFlag(mov), .window1Flag(w1), .window2Flag(w2), .window3Flag(w3),
        .stepCyclePulse(tim), .internalBusyFlag(busy), .startEcho(stE), .freeEcho(fr), .currentOffEcho(co),
        .stopEcho(so), .dataSelectEcho(dsE), .positiveLimitEcho(pl), .negativeLimitEcho(nl),
        .homeSensorEcho(hs), .slitEcho(sl), .directOutputs(dOut), .networkOutBits(netOut));
    // free-running clock and timing pulse counter
    always #5 mclk = ~mclk;
    always @(posedge mclk) if (tim === 1'b1) pulses++;
    // pseudo random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // output group picked by a note
    function automatic logic [15:0] obs(input int s);
        case (s)
            0: return {15'h0000, rdy};
            1: return {15'h0000, home};
            2: return {15'h0000, mov};
            3: return {13'h0000, w3, w2, w1};
            4: return {15'h0000, busy};
            5: return {3'h0, stE};
            6: return {3'h0, dsE, pl, nl, hs, sl, so, co, fr};
            7: return {10'h000, dOut};
            8: return netOut;
            default: return pulses[15:0];
        endcase
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        if (fail_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // advance n edges, then settle by the fixed drive delay
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic want(input int s, input logic [15:0] e);
        selQ.push_back(s);
        expQ.push_back(e);
        -> chk;
    endtask
    // bound write, strobe left high for back-to-back writes
    task automatic wb(input logic [1:0] i, input logic n, input logic [23:0] v);
        bIdx = i;
        bNeg = n;
        bVal = v;
        bWr = 1'b1;
        tick(1);
    endtask
    // watcher drains every queued note, oldest first, when results are posted
    always @(chk)
    begin
        while (selQ.size() > 0) check(obs(selQ.pop_front()), expQ.pop_front());
    end
    initial
    begin
        #60000;
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        tick(12);
        want(0, 16'h0000);
        want(3, 16'h0000);
        resetn = 1'b1;
        tick(2);
        want(0, 16'h0001);
        for (int i = 0; i < 8; i++)
        begin
            blk = 8'h01 << i;
            tick(2);
            want(0, 16'h0000);
            blk = 8'h00;
            tick(3);
        end
        startReq = 1'b1;
        tick(3);
        startReq = 1'b0;
        tick(2);
        want(0, 16'h0001);
        repeat (3)
        begin
            rnd = lfsr(rnd);
            stIn = rnd[12:0];
            eIn = rnd[22:13];
            blk = {3'h0, rnd[25:23], 2'h0};
            tick(1);
            want(5, {3'h0, stIn});
            want(6, {3'h0, eIn, blk[4:2]});
        end
        stIn = 13'h0000;
        blk = 8'h00;
        maint = 1'b1;
        tick(1);
        want(4, 16'h0001);
        maint = 1'b0;
        wb(2'h0, 1'b0, 24'h00000A);
        wb(2'h0, 1'b1, 24'hFFFFFB);
        wb(2'h1, 1'b0, 24'hFFFFFB);
        wb(2'h1, 1'b1, 24'h00000A);
        wb(2'h3, 1'b0, 24'h000005);
        bWr = 1'b0;
        want(4, 16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            cmdPos = posT[i];
            tick(2);
            want(3, winT[i]);
        end
        oSet = 1'b1;
        cmdPos = 24'h000000;
        tick(2);
        want(1, 16'h0001);
        oSet = 1'b0;
        tick(2);
        want(1, 16'h0000);
        hSel = 1'b1;
        oSet = 1'b1;
        cmdPos = 24'h000064;
        oEvt = 1'b1;
        tick(1);
        oEvt = 1'b0;
        tick(2);
        want(1, 16'h0001);
        blk = 8'h01;
        cmdPos = 24'h0000C8;
        tick(3);
        want(1, 16'h0000);
        want(2, 16'h0001);
        blk = 8'h00;
        tick(25);
        want(2, 16'h0000);
        blk = 8'h01;
        tick(1);
        blk = 8'h00;
        tick(10);
        want(2, 16'h0001);
        tick(15);
        want(2, 16'h0000);
        stp = 1'b1;
        tick(4);
        fwd = 1'b0;
        tick(2);
        stp = 1'b0;
        tick(3);
        want(9, 16'h0003);
        repeat (4)
        begin
            rnd = lfsr(rnd);
            netIn = rnd[15:0];
            dIn = rnd[23:16];
            dLvl = {4'h0, rnd[24], 3'h0};
            tick(2);
            want(7, {15'h0000, rnd[0]});
            want(8, {rnd[19] ^ rnd[24], 15'h0000});
        end
        #1 report_and_stop(); // let the watcher drain the last notes first
    end
endmodule // tb_top
`default_nettype wire
